// ==== bench/dfd_host_model.sv ====
`timescale 1ns/100ps
module dfd_host_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // device pins
  input  wire logic        singleBreakRequest,
  input  wire logic        busReadReq,
  input  wire logic        busWriteReq,
  input  wire logic [16:0] busAddrOut,
  input  wire logic [17:0] busDataOut,
  input  wire logic [3:0]  stallCyc,
  // host pins
  output logic             busSync,
  output logic             busGrant,
  output logic             busIoPulseFour,
  output logic [17:0]      busDataIn,
  output logic [17:0]      savedWord
);
  logic [2:0] syncCnt;
  function automatic logic [17:0] memWord(input logic [16:0] a);
    return {a[0], a} ^ 18'h2B4D3;
  endfunction : memWord
  // sync runs free, so a request may meet it at any phase
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst)
      syncCnt <= 3'h0;
    else
      syncCnt <= syncCnt + 3'h1;
  end
  assign busSync = (syncCnt[2:1] == 2'h3);
  initial begin
    busGrant = 1'b0;
    busIoPulseFour = 1'b0;
    busDataIn = 18'h3FFFF;
    savedWord = 18'h00000;
    forever begin
      @(posedge sys_clk);
      if (singleBreakRequest === 1'b1 && sys_rst === 1'b0) begin
        repeat (stallCyc) @(posedge sys_clk);
        busGrant <= 1'b1;
        while (busReadReq !== 1'b1 && busWriteReq !== 1'b1) @(posedge sys_clk);
        if (busReadReq === 1'b1) begin
          savedWord <= busDataOut;
          @(posedge sys_clk);
          busGrant <= 1'b0;
        end else begin
          busDataIn <= memWord(busAddrOut);
          repeat (2) @(posedge sys_clk);
          busIoPulseFour <= 1'b1;
          repeat (2) @(posedge sys_clk);
          // grant falls with the last pulse, so no stale award meets the next request
          busIoPulseFour <= 1'b0;
          busGrant <= 1'b0;
          repeat (6) @(posedge sys_clk);
          // released data lines must not keep looking valid
          busDataIn <= ~busDataIn;
        end
      end
    end
  end
endmodule : dfd_host_model

// ==== bench/test_display_file_data_channel_fetch.sv ====
`timescale 1ns/100ps
`include "dfd_params.svh"
module test_display_file_data_channel_fetch;
  import dfd_pkg::*;
  logic        sys_clk, sys_rst, busSync, busGrant, busIoPulseFour, busDataOe_n, busAddrOe_n, busReadReq;
  logic        singleBreakRequest, busWriteReq, wordRequest, wordOutbound, ioCmdMatch, operationComplete;
  logic        charReadyLevel, textStringMode, busOwnershipEnable, hostTookData, wordAvailable;
  logic        bufferTransfer, wordPresentLevel, chanBusy, inMs1;
  logic [17:0] busDataIn, busDataOut, storeData, ioReadData, activeWord, stringWord, savedWord, d;
  logic [16:0] busAddrOut, fetchAddr, a;
  logic [16:0] addrs[3];
  logic [3:0]  opcode4, timeState, stallCyc;
  logic [2:0]  opcode3;
  logic [31:0] seed;
  int          fails, checkCount, cycles, n;
  assign inMs1 = (timeState === DFD_MS1);
  dfd_fetch DUT (.sys_clk, .sys_rst, .busSync, .busGrant, .busIoPulseFour, .busDataIn, .busDataOut,
    .busDataOe_n, .busAddrOut, .busAddrOe_n, .singleBreakRequest, .busReadReq, .busWriteReq, .wordRequest,
    .wordOutbound, .fetchAddr, .storeData, .ioCmdMatch, .ioReadData, .operationComplete, .charReadyLevel,
    .textStringMode, .activeWord, .stringWord, .opcode4, .opcode3, .busOwnershipEnable, .hostTookData,
    .wordAvailable, .bufferTransfer, .wordPresentLevel, .timeState, .chanBusy);
  dfd_host_model HOST (.sys_clk, .sys_rst, .singleBreakRequest, .busReadReq, .busWriteReq, .busAddrOut,
    .busDataOut, .stallCyc, .busSync, .busGrant, .busIoPulseFour, .busDataIn, .savedWord);
  function automatic logic [17:0] memWord(input logic [16:0] x);
    return {x[0], x} ^ 18'h2B4D3;
  endfunction : memWord
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checkCount++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(ref logic s, input int lim);
    int k;
    k = 0;
    while (s !== 1'b1 && k < lim) begin
      @(negedge sys_clk);
      k++;
    end
    chk({17'h0, s}, 18'h1);
  endtask : wt
  task automatic xf(input logic [16:0] x, input logic ob, input logic [17:0] w);
    @(posedge sys_clk);
    fetchAddr <= x;
    wordOutbound <= ob;
    storeData <= w;
    stallCyc <= 4'($random(seed));
    wordRequest <= 1'b1;
    wt(singleBreakRequest, 100);
    @(posedge sys_clk);
    wordRequest <= 1'b0;
    wt(busOwnershipEnable, 100);
    chk({1'b0, busAddrOut}, {1'b0, x});
    chk({14'h0, busAddrOe_n, singleBreakRequest, busReadReq, busWriteReq}, {16'h0, ob, !ob});
    if (ob) begin
      chk({17'h0, busDataOe_n}, 18'h0);
      chk(busDataOut, w);
      wt(hostTookData, 100);
    end else
      wt(wordAvailable, 100);
    repeat (3) @(negedge sys_clk);
    chk({17'h0, chanBusy}, 18'h0);
  endtask : xf
  task automatic tr(input logic str, input logic [17:0] w);
    @(posedge sys_clk);
    if (str)
      charReadyLevel <= 1'b1;
    else
      operationComplete <= 1'b1;
    wt(bufferTransfer, 300);
    wt(inMs1, 10);
    n = 0;
    while (inMs1 === 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    chk(18'(n), 18'(`DFD_TSTATE_CYC));
    @(posedge sys_clk);
    operationComplete <= 1'b0;
    charReadyLevel <= 1'b0;
    @(negedge sys_clk);
    chk(activeWord, w);
    chk({11'h0, opcode4, opcode3}, {11'h0, w[17:14], w[17:15]});
  endtask : tr
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // bound on the whole run; a hang counts against it
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("ERROR t=%0t timeout got=%h exp=%h", $time, cycles, 0);
      tally_and_finish();
    end
  end
  initial begin
    seed = 32'h609A7BC3;
    {sys_rst, wordRequest, wordOutbound, ioCmdMatch, operationComplete, charReadyLevel, textStringMode} = 7'h40;
    {fetchAddr, storeData, ioReadData, stallCyc} = '0;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({12'h0, busDataOe_n, busAddrOe_n, timeState}, {12'h0, 2'b11, DFD_MS0});
    @(posedge sys_clk);
    ioReadData <= 18'($random(seed));
    ioCmdMatch <= 1'b1;
    @(negedge sys_clk);
    chk({17'h0, busDataOe_n}, 18'h0);
    chk(busDataOut, ioReadData);
    @(posedge sys_clk);
    ioCmdMatch <= 1'b0;
    $display("test io done");
    for (int i = 0; i < 6; i++) begin
      a = 17'($random(seed));
      d = 18'($random(seed));
      xf(a, i[0], d);
      if (i[0])
        chk(savedWord, d);
      else begin
        chk({wordPresentLevel, stringWord}, {1'b1, memWord(a)});
        chk(activeWord, i == 0 ? 18'h0 : memWord(addrs[0]));
        tr(1'b0, memWord(a));
        addrs[0] = a;
      end
    end
    $display("test random done");
    for (int i = 0; i < 3; i++) begin
      addrs[i] = 17'($random(seed));
      xf(addrs[i], 1'b0, 18'h0);
    end
    @(posedge sys_clk);
    wordRequest <= 1'b1;
    n = 0;
    repeat (60) begin
      @(negedge sys_clk);
      n += (singleBreakRequest === 1'b1);
    end
    chk(18'(n), 18'h0);
    @(posedge sys_clk);
    wordRequest <= 1'b0;
    for (int i = 0; i < 3; i++)
      tr(1'b0, memWord(addrs[i]));
    $display("test buffer done");
    textStringMode <= 1'b1;
    a = 17'($random(seed));
    xf(a, 1'b0, 18'h0);
    @(posedge sys_clk);
    operationComplete <= 1'b1;
    n = 0;
    repeat (200) begin
      @(negedge sys_clk);
      n += (bufferTransfer === 1'b1);
    end
    chk(18'(n), 18'h0);
    @(posedge sys_clk);
    operationComplete <= 1'b0;
    tr(1'b1, memWord(a));
    a = 17'($random(seed));
    xf(a, 1'b0, 18'h0);
    chk(stringWord, memWord(a));
    $display("test string done");
    tally_and_finish();
  end
endmodule : test_display_file_data_channel_fetch

// ==== hw/dfd_fetch.sv ====
`timescale 1ns/100ps
`include "dfd_params.svh"
module dfd_fetch #(
  parameter int WORD_W = `DFD_WORD_W,
  parameter int ADDR_W = `DFD_ADDR_W
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  // host bus pins
  input  wire logic               busSync,
  input  wire logic               busGrant,
  input  wire logic               busIoPulseFour,
  input  wire logic [WORD_W-1:0]  busDataIn,
  output logic      [WORD_W-1:0]  busDataOut,
  output logic                    busDataOe_n,
  output logic      [ADDR_W-1:0]  busAddrOut,
  output logic                    busAddrOe_n,
  output logic                    singleBreakRequest,
  output logic                    busReadReq,
  output logic                    busWriteReq,
  // processor side
  input  wire logic               wordRequest,
  input  wire logic               wordOutbound,
  input  wire logic [ADDR_W-1:0]  fetchAddr,
  input  wire logic [WORD_W-1:0]  storeData,
  input  wire logic               ioCmdMatch,
  input  wire logic [WORD_W-1:0]  ioReadData,
  input  wire logic               operationComplete,
  input  wire logic               charReadyLevel,
  input  wire logic               textStringMode,
  // decoder side
  output logic      [WORD_W-1:0]  activeWord,
  output logic      [WORD_W-1:0]  stringWord,
  output logic      [3:0]         opcode4,
  output logic      [2:0]         opcode3,
  output logic                    busOwnershipEnable,
  output logic                    hostTookData,
  output logic                    wordAvailable,
  output logic                    bufferTransfer,
  output logic                    wordPresentLevel,
  output logic      [3:0]         timeState,
  output logic                    chanBusy
);
  import dfd_pkg::*;

  localparam int TS_CYC = `DFD_TSTATE_CYC;
  localparam int TS_W   = $clog2(TS_CYC + 1);

  // pin synchronisers
  logic [2:0] syncA_r;
  logic [2:0] syncB_r;
  logic [2:0] pinLvl_r;
  logic [WORD_W-1:0] dataA_r;
  logic [WORD_W-1:0] dataB_r;
  wire        syncLvl  = pinLvl_r[0];
  wire        grantLvl = pinLvl_r[1];
  wire        iop4Lvl  = pinLvl_r[2];

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA_r  <= 3'h0;
      syncB_r  <= 3'h0;
      pinLvl_r <= 3'h0;
      dataA_r  <= `DFD_RST_WORD;
      dataB_r  <= `DFD_RST_WORD;
    end else begin
      syncA_r  <= {busIoPulseFour, busGrant, busSync};
      syncB_r  <= syncA_r;
      pinLvl_r <= syncB_r;
      dataA_r  <= busDataIn;
      dataB_r  <= dataA_r;
    end
  end

  // edges seen on synchronised levels only
  wire grantFall = pinLvl_r[1] && !syncB_r[1];
  wire iop4Fall  = pinLvl_r[2] && !syncB_r[2];

  // channel sequence
  dfd_chan_t chan_r;
  dfd_chan_t chan_nxt;
  logic      pending_r;
  logic      outbound_r;
  logic      own_r;
  logic      holdFull_r;
  logic [WORD_W-1:0] hold_r;
  logic [WORD_W-1:0] outWord_r;
  logic [ADDR_W-1:0] addr_r;
  dfd_tstate_t       tstate_r;
  logic [TS_W-1:0]   tsCnt_r;
  logic              running_r;
  wire               tsTick = (tsCnt_r == TS_W'(TS_CYC - 1));

  wire bufReady;
  // an award level left high from the last break would count as fresh; the host must drop it first
  wire startBreak = (chan_r == DFD_IDLE) && wordRequest && syncLvl && bufReady;
  wire ownSet     = (chan_r == DFD_REQ) && pending_r && grantLvl;
  wire tookPulse  = own_r && outbound_r && grantFall;
  wire availPulse = own_r && !outbound_r && iop4Fall;

  always_comb begin
    chan_nxt = chan_r;
    unique case (chan_r)
      DFD_IDLE: if (startBreak) chan_nxt = DFD_REQ;
      DFD_REQ:  if (ownSet) chan_nxt = DFD_OWN;
      DFD_OWN:  if (tookPulse || availPulse) chan_nxt = DFD_DONE;
      DFD_WAIT: chan_nxt = DFD_DONE;
      DFD_DONE: chan_nxt = DFD_IDLE;
      default:  chan_nxt = DFD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      chan_r     <= DFD_IDLE;
      pending_r  <= 1'b0;
      outbound_r <= 1'b0;
      own_r      <= 1'b0;
      addr_r     <= `DFD_RST_ADDR;
      outWord_r  <= `DFD_RST_WORD;
    end else begin
      chan_r <= chan_nxt;
      if (startBreak) begin
        pending_r  <= 1'b1;
        outbound_r <= wordOutbound;
        addr_r     <= fetchAddr;
        outWord_r  <= storeData;
      end else if (ownSet) begin
        pending_r <= 1'b0;
      end
      if (ownSet) begin
        own_r <= 1'b1;
      end else if (tookPulse || availPulse) begin
        own_r <= 1'b0;
      end
    end
  end

  // bus drive; address leaves with ownership, data only with outbound ownership or an io command match
  assign singleBreakRequest = pending_r;
  assign busOwnershipEnable = own_r;
  assign busAddrOut         = addr_r;
  assign busAddrOe_n        = !own_r;
  assign busReadReq         = own_r && outbound_r;
  assign busWriteReq        = own_r && !outbound_r;
  wire   driveStore         = own_r && outbound_r;
  assign busDataOe_n        = !(driveStore || ioCmdMatch);
  assign busDataOut         = driveStore ? outWord_r : ioReadData;
  assign hostTookData       = tookPulse;
  assign wordAvailable      = availPulse;
  assign chanBusy           = (chan_r != DFD_IDLE);

  // holding buffer; a stalled decoder backs up into the skid pair
  wire holdReady = !holdFull_r;
  wire skidValid;
  wire [WORD_W-1:0] skidData;
  wire xferFire;

  dfd_skid2 #(
    .WIDTH (WORD_W)
  ) uSkid (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .inValid  (availPulse),
    .inReady  (bufReady),
    .inData   (dataB_r),
    .outValid (skidValid),
    .outReady (holdReady || xferFire),
    .outData  (skidData)
  );

  wire holdLoad = skidValid && (holdReady || xferFire);
  assign wordPresentLevel = holdFull_r;
  wire xferCond = textStringMode ? charReadyLevel : operationComplete;
  assign xferFire = holdFull_r && xferCond && (tstate_r == DFD_MS0) && tsTick;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      holdFull_r <= 1'b0;
      hold_r     <= `DFD_RST_WORD;
      activeWord <= `DFD_RST_WORD;
    end else begin
      if (holdLoad) begin
        hold_r     <= skidData;
        holdFull_r <= 1'b1;
      end else if (xferFire) begin
        holdFull_r <= 1'b0;
      end
      if (xferFire) begin
        activeWord <= hold_r;
      end
    end
  end

  assign bufferTransfer = xferFire;
  assign stringWord     = hold_r;
  assign opcode4 = activeWord[`DFD_OPC_MSB:`DFD_OPC4_LSB];
  assign opcode3 = activeWord[`DFD_OPC_MSB:`DFD_OPC3_LSB];

  // main timing: MS1 to MS3 each last one basic clock period; MS0 holds until a buffer transfer

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tstate_r  <= DFD_MS0;
      tsCnt_r   <= '0;
      running_r <= 1'b0;
    end else begin
      tsCnt_r <= tsTick ? '0 : tsCnt_r + TS_W'(1);
      if (xferFire) begin
        running_r <= 1'b1;
      end else if (tsTick && tstate_r == DFD_MS3) begin
        running_r <= 1'b0;
      end
      if (tsTick) begin
        unique case (tstate_r)
          DFD_MS0: if (running_r || xferFire) tstate_r <= DFD_MS1;
          DFD_MS1: tstate_r <= DFD_MS2;
          DFD_MS2: tstate_r <= DFD_MS3;
          DFD_MS3: tstate_r <= DFD_MS0;
        endcase
      end
    end
  end
  assign timeState = tstate_r;

  // checks
  AST_REQ_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (pending_r && !ownSet) |=> pending_r)
    else $error("pending request dropped before ownership");
  AST_OWN_SET: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (chan_r == DFD_REQ && pending_r && grantLvl) |=> (own_r && !pending_r))
    else $error("ownership not taken on award");
  AST_ADDR_DRIVE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    own_r |-> (!busAddrOe_n && (busReadReq != busWriteReq)))
    else $error("address or direction not driven while owning");
  AST_STORE_DATA: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (own_r && outbound_r) |-> (!busDataOe_n && busDataOut == outWord_r))
    else $error("outbound word not on bus");
  AST_DRV_ONLY: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !busDataOe_n |-> (ioCmdMatch || (own_r && outbound_r)))
    else $error("data drivers enabled without cause");
  sequence seqTook;
    own_r && outbound_r && pinLvl_r[1] ##1 !pinLvl_r[1];
  endsequence
  sequence seqAvail;
    own_r && !outbound_r && pinLvl_r[2] ##1 !pinLvl_r[2];
  endsequence
  AST_TOOK: assert property (@(posedge sys_clk) disable iff (sys_rst)
    seqTook |-> ($past(hostTookData) && !own_r && chan_r == DFD_DONE))
    else $error("award fall did not end outbound transfer");
  AST_AVAIL_FALL: assert property (@(posedge sys_clk) disable iff (sys_rst)
    seqAvail |-> ($past(wordAvailable) && !own_r && chan_r == DFD_DONE))
    else $error("io pulse four fall did not end inbound fetch");
  AST_AVAIL_LOAD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wordAvailable |-> ##[1:3] holdFull_r)
    else $error("fetched word not reaching holding buffer");
  AST_BUFFER_TRANSFER: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bufferTransfer |=> (activeWord == $past(hold_r) && tstate_r == DFD_MS1))
    else $error("transfer did not load active buffer and restart");
  AST_ACTIVE_STABLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !bufferTransfer |=> $stable(activeWord))
    else $error("active buffer changed without transfer");
  AST_OPCODE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    opcode3 == opcode4[3:1])
    else $error("opcode fields disagree");
  AST_BREAK_START: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(singleBreakRequest) |-> $past(wordRequest && syncLvl))
    else $error("break request raised without word request and sync");
  AST_REQ_NOT_OWN: assert property (@(posedge sys_clk) disable iff (sys_rst)
    own_r |-> !singleBreakRequest)
    else $error("new break request during a transfer");
  AST_IDLE_QUIET: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (chan_r == DFD_IDLE) |-> (busAddrOe_n && !busReadReq && !busWriteReq))
    else $error("bus driven while channel idle");
  AST_TS_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !tsTick |=> $stable(tstate_r))
    else $error("time state moved inside a basic clock period");
  AST_STR_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (textStringMode && !charReadyLevel) |-> !bufferTransfer)
    else $error("string transfer without char ready level");
  AST_HOLD_STABLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !holdLoad |=> $stable(hold_r))
    else $error("holding buffer changed without a load");
endmodule : dfd_fetch

// ==== hw/dfd_skid2.sv ====
`timescale 1ns/100ps
`include "dfd_params.svh"
module dfd_skid2 #(
  parameter int WIDTH = `DFD_WORD_W
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] mem_r [2];
  logic             wrPtr_r;
  logic             rdPtr_r;
  logic [1:0]       count_r;
  wire              doPush = inValid && inReady;
  wire              doPop  = outValid && outReady;

  assign inReady  = (count_r != 2'h2);
  assign outValid = (count_r != 2'h0);
  assign outData  = mem_r[rdPtr_r];

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'h0;
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end else begin
      if (doPush) begin
        mem_r[wrPtr_r] <= inData;
        wrPtr_r        <= ~wrPtr_r;
      end
      if (doPop) begin
        rdPtr_r <= ~rdPtr_r;
      end
      if (doPush && !doPop) begin
        count_r <= count_r + 2'h1;
      end else if (doPop && !doPush) begin
        count_r <= count_r - 2'h1;
      end
    end
  end
endmodule : dfd_skid2

// ==== include/dfd_params.svh ====
`ifndef DFD_PARAMS_SVH
`define DFD_PARAMS_SVH
`define DFD_CLK_PERIOD_PS   4000
`define DFD_TSTATE_NS       250
`define DFD_TSTATE_CYC      (((`DFD_TSTATE_NS) * 1000 + (`DFD_CLK_PERIOD_PS) - 1) / (`DFD_CLK_PERIOD_PS))
`define DFD_WORD_W          18
`define DFD_ADDR_W          17
`define DFD_OPC_MSB         17
`define DFD_OPC3_LSB        15
`define DFD_OPC4_LSB        14
`define DFD_RST_WORD        18'h00000
`define DFD_RST_ADDR        17'h00000
`endif

// ==== include/dfd_pkg.sv ====
package dfd_pkg;
  typedef enum logic [4:0] {
    DFD_IDLE  = 5'b00001,
    DFD_REQ   = 5'b00010,
    DFD_OWN   = 5'b00100,
    DFD_WAIT  = 5'b01000,
    DFD_DONE  = 5'b10000
  } dfd_chan_t;
  typedef enum logic [3:0] {
    DFD_MS0 = 4'b0001,
    DFD_MS1 = 4'b0010,
    DFD_MS2 = 4'b0100,
    DFD_MS3 = 4'b1000
  } dfd_tstate_t;
endpackage : dfd_pkg
